// *** logic/upper_timer_pkg.sv ***
/*
 Package for the cascadable upper timer/counter unit: register offsets,
 field positions, reset values, mode and clock-select encodings, carriers.
 Assumes nothing of its surroundings.
*/
package upper_timer_pkg;

    localparam int          ADDR_W          = 5;
    localparam logic [4:0]  OFF_CONTROL     = 5'h00;
    localparam logic [4:0]  OFF_PERIOD      = 5'h04;
    localparam logic [4:0]  OFF_WIDTH       = 5'h08;
    localparam logic [4:0]  OFF_STATUS      = 5'h0C;
    localparam logic [4:0]  OFF_MASK        = 5'h10;
    localparam logic [4:0]  OFF_COUNT       = 5'h14;
    localparam logic [4:0]  OFF_MISC        = 5'h18;

    localparam int          POS_FF          = 7;
    localparam int          POS_CLK         = 4;
    localparam int          POS_RUN         = 3;
    localparam int          POS_MODE        = 0;
    localparam int          POS_DIVSEL      = 0;
    localparam int          POS_OUTDIS      = 1;
    localparam int          POS_SLOW        = 2;

    localparam logic [7:0]  RST_CONTROL     = 8'h00;
    localparam logic [7:0]  RST_PERIOD      = 8'hFF;
    localparam logic [7:0]  RST_WIDTH       = 8'h80;
    localparam logic [1:0]  RST_IRQ         = 2'h0;
    localparam logic [2:0]  RST_MISC        = 3'h2;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Clock select taps into the free-running prescaler
    localparam int          TAP_CS0         = 11;
    localparam int          TAP_CS1         = 7;
    localparam int          TAP_CS2         = 5;
    localparam int          TAP_CS3         = 3;
    localparam int          TAP_FS3         = 3;
    localparam int          PRE_W           = 12;
    localparam int          FS_PRE_W        = 4;

    typedef enum logic [2:0] {
        MODE_TIMER8  = 3'h0,
        MODE_PDO8    = 3'h1,
        MODE_PWM8    = 3'h2,
        MODE_RSVD3   = 3'h3,
        MODE_TIMER16 = 3'h4,
        MODE_WARMUP  = 3'h5,
        MODE_PWM16   = 3'h6,
        MODE_PPG16   = 3'h7
    } mode_type;

    typedef struct packed {
        logic       ffCtrl;
        logic [2:0] clkSel;
        logic       run;
        logic [2:0] mode;
    } control_type;

    // Lower unit's interface to this one
    typedef struct packed {
        logic       overflow;
        logic [7:0] count;
        logic [7:0] periodLow;
        logic [7:0] widthLow;
    } lower_link_type;

endpackage

// *** logic/tick_select.sv ***
/*
 Source clock selector: turns prescaler edges into a one-cycle count tick.
 Assumes high/low frequency clock enables and the pin level are synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module tick_select (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire logic [2:0]                 clkSel,
    input  wire logic                       divSel,
    input  wire logic                       slowMode,
    input  wire logic                       highFreqTick,
    input  wire logic                       lowFreqTick,
    input  wire logic                       extPin,
    output logic                            tick
);
    import upper_timer_pkg::*;

    logic [PRE_W-1:0]    hfPre_q;
    logic [FS_PRE_W-1:0] lfPre_q;
    logic [PRE_W-1:0]    hfPre_d;
    logic [FS_PRE_W-1:0] lfPre_d;
    logic                pinDly_q;
    logic                tick_d;

    // Tap goes high for one tick when all lower bits roll over
    function automatic logic rolls(input logic [PRE_W-1:0] pre, input int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            ok = ok & pre[i];
        end
        return ok;
    endfunction

    assign hfPre_d = hfPre_q + PRE_W'(1);
    assign lfPre_d = lfPre_q + FS_PRE_W'(1);

    wire hfRoll = highFreqTick;
    wire lfDiv8 = lowFreqTick & (&lfPre_q[TAP_FS3-1:0]);
    wire pinRise = extPin & ~pinDly_q;

    always_comb begin
        tick_d = 1'b0;
        case (clkSel)
            3'h0: tick_d = (divSel | slowMode) ? lfDiv8
                         : hfRoll & rolls(hfPre_q, TAP_CS0);
            3'h1: tick_d = ~slowMode & hfRoll & rolls(hfPre_q, TAP_CS1);
            3'h2: tick_d = ~slowMode & hfRoll & rolls(hfPre_q, TAP_CS2);
            3'h3: tick_d = ~slowMode & hfRoll & rolls(hfPre_q, TAP_CS3);
            3'h4: tick_d = lowFreqTick;
            3'h5: tick_d = ~slowMode & hfRoll & hfPre_q[0];
            3'h6: tick_d = ~slowMode & hfRoll;
            3'h7: tick_d = pinRise;
            default: tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hfPre_q  <= '0;
            lfPre_q  <= '0;
            pinDly_q <= 1'b0;
            tick     <= 1'b0;
        end else begin
            if (highFreqTick) hfPre_q <= hfPre_d;
            if (lowFreqTick) lfPre_q <= lfPre_d;
            pinDly_q <= extPin;
            tick     <= tick_d;
        end
    end
endmodule
`default_nettype wire

// *** logic/upper_timer.sv ***
/*
 Upper unit of a cascadable pair of 8-bit timer/counters, AXI4-Lite slave.
 Assumes the lower unit supplies overflow, count and low compare bytes,
 and that its own clock selector tick arrives on lowerTick in 16-bit modes.
*/
// What this block does
// - The clock select picks a divided high/low clock or the pin as the count source.
// - Clearing the run bit stops and clears the counter; setting it starts counting.
// - The mode field picks timer, divider, PWM, 16-bit timer, warm-up, 16-bit PWM or pulse gen.
// - With the mode top bit set, the unit counts the lower unit's overflow.
// - In 16-bit modes the source is the lower clock select; run and flip-flop come from here.
// - The output disable bit suppresses pulses on the timer pin in pulse modes.
// - In 8-bit timer mode a period match sets status bit 0 (an interrupt only if mask bit 0 is set) and clears the counter.
`timescale 1ns/1ns
`default_nettype none
module upper_timer (
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    input  wire logic [upper_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [upper_timer_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic                           highFreqTick,
    input  wire logic                           lowFreqTick,
    input  wire logic                           extPin,
    input  wire logic                           lowerTick,
    input  wire upper_timer_pkg::lower_link_type lowerLink,
    output logic                                timerOut,
    output logic                                matchPulse,
    output logic                                irq
);
    import upper_timer_pkg::*;

    control_type ctrl_q;
    logic [7:0]  period_q;
    logic [7:0]  width_q;
    logic [7:0]  widthBuf_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [2:0]  misc_q;
    logic [7:0]  count_q;
    logic        ff_q;
    logic        awHeld_q;
    logic        wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        ownTick;

    // Write channel: capture address and data in either order
    wire awTake  = s_axi_awvalid & s_axi_awready;
    wire wTake   = s_axi_wvalid & s_axi_wready;
    wire haveAw  = awHeld_q | awTake;
    wire haveW   = wHeld_q | wTake;
    wire [ADDR_W-1:0] wAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wire [31:0] wDat  = wHeld_q ? wData_q : s_axi_wdata;
    wire        wLane = wHeld_q ? wStrb_q[0] : s_axi_wstrb[0];
    wire doWrite = haveAw & haveW & ~s_axi_bvalid;
    wire wrOk    = wLane & doWrite;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CONTROL) | (a == OFF_PERIOD) | (a == OFF_WIDTH) |
               (a == OFF_STATUS) | (a == OFF_MASK) | (a == OFF_COUNT) |
               (a == OFF_MISC);
    endfunction

    // A compare hits on the step that carries the count onto its limit
    function automatic logic lastStep8(input logic [7:0] cnt, input logic [7:0] lim);
        return cnt == (lim - 8'h01);
    endfunction

    function automatic logic lastStep16(input logic [15:0] cnt, input logic [15:0] lim);
        return cnt == (lim - 16'h0001);
    endfunction

    wire wrCtrl   = wrOk & (wAddr == OFF_CONTROL);
    wire wrPeriod = wrOk & (wAddr == OFF_PERIOD);
    wire wrWidth  = wrOk & (wAddr == OFF_WIDTH);
    wire wrStatus = wrOk & (wAddr == OFF_STATUS);
    wire wrMask   = wrOk & (wAddr == OFF_MASK);
    wire wrMisc   = wrOk & (wAddr == OFF_MISC);

    // Mode decode
    wire        wide     = ctrl_q.mode[2];
    wire        isPdo8   = ctrl_q.mode == MODE_PDO8;
    wire        isPwm8   = ctrl_q.mode == MODE_PWM8;
    wire        isPwm16  = ctrl_q.mode == MODE_PWM16;
    wire        isPpg16  = ctrl_q.mode == MODE_PPG16;
    wire        isPwm    = isPwm8 | isPwm16;
    wire        pulseMode = isPdo8 | isPwm | isPpg16;
    wire        running  = ctrl_q.run;

    // Count source: own selector, or lower overflow/tick when cascaded
    wire step = wide ? lowerLink.overflow : ownTick;

    // Combined counts and compares, lower unit as the low byte
    wire [15:0] cnt16    = {count_q, lowerLink.count};
    wire [15:0] per16    = {period_q, lowerLink.periodLow};
    wire [15:0] wid16    = {width_q, lowerLink.widthLow};
    wire        lowStep  = lowerTick;
    wire        match8   = step & lastStep8(count_q, period_q);
    wire        wMatch8  = step & lastStep8(count_q, widthBuf_q);
    wire        match16  = lowStep & lastStep16(cnt16, per16);
    wire        wMatch16 = lowStep & lastStep16(cnt16, wid16);
    wire        wrap8    = step & (count_q == 8'hFF);
    wire        wrap16   = lowStep & (cnt16 == 16'hFFFF);

    logic       clearCnt;
    logic       periodHit;
    logic       ffToggle;
    logic       ffSetHit;
    always_comb begin
        clearCnt  = 1'b0;
        periodHit = 1'b0;
        ffToggle  = 1'b0;
        ffSetHit  = 1'b0;
        case (ctrl_q.mode)
            MODE_TIMER8, MODE_PDO8: begin
                periodHit = match8;
                clearCnt  = match8;
                ffToggle  = isPdo8 & match8;
            end
            MODE_PWM8: begin
                periodHit = wrap8;
                ffToggle  = wMatch8 | wrap8;
            end
            MODE_TIMER16, MODE_WARMUP: begin
                periodHit = match16;
                clearCnt  = match16 & ~ctrl_q.mode[0];
            end
            MODE_PWM16: begin
                periodHit = wrap16;
                ffToggle  = wMatch16 | wrap16;
            end
            MODE_PPG16: begin
                periodHit = match16;
                clearCnt  = match16;
                ffToggle  = wMatch16;
                ffSetHit  = match16;
            end
            default: begin
                periodHit = 1'b0;
            end
        endcase
    end

    // Read mux
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (s_axi_araddr)
            OFF_CONTROL: rdMux = {24'h000000, ctrl_q};
            OFF_PERIOD:  rdMux = {24'h000000, period_q};
            OFF_WIDTH:   rdMux = {24'h000000, width_q};
            OFF_STATUS:  rdMux = {30'h00000000, status_q};
            OFF_MASK:    rdMux = {30'h00000000, mask_q};
            OFF_COUNT:   rdMux = {24'h000000, count_q};
            OFF_MISC:    rdMux = {29'h00000000, misc_q};
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    // Only a starting write loads the flip-flop; a stopping write leaves it
    wire runStart = wrCtrl & wDat[POS_RUN] & ~running;
    wire [1:0] events = {wrap8 & ~wide, periodHit};

    // Bit 1 flags the 8-bit wrap, bit 0 the period end
    // A set in the same cycle as a clearing write wins
    logic [1:0] statusNext;
    for (genvar b = 0; b < 2; b++) begin : g_status
        assign statusNext[b] = (running & events[b]) | (status_q[b] & ~(wrStatus & wDat[b]));
    end

    tick_select u_tick (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .clkSel       (ctrl_q.clkSel),
        .divSel       (misc_q[POS_DIVSEL]),
        .slowMode     (misc_q[POS_SLOW]),
        .highFreqTick (highFreqTick),
        .lowFreqTick  (lowFreqTick),
        .extPin       (extPin),
        .tick         (ownTick)
    );

    // AXI handshake
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            awHeld_q      <= haveAw & ~doWrite;
            wHeld_q       <= haveW & ~doWrite;
            // Readies stay low while an answer is pending: one transfer at a time
            s_axi_awready <= ~haveAw & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready  <= ~haveW & ~s_axi_bvalid & ~s_axi_wready;
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Software-visible registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q     <= RST_CONTROL;
            period_q   <= RST_PERIOD;
            width_q    <= RST_WIDTH;
            widthBuf_q <= RST_WIDTH;
            status_q   <= RST_IRQ;
            mask_q     <= RST_IRQ;
            misc_q     <= RST_MISC;
        end else begin
            if (wrCtrl) ctrl_q <= wDat[7:0];
            if (wrPeriod) period_q <= wDat[7:0];
            if (wrWidth) width_q <= wDat[7:0];
            if (wrMask) mask_q <= wDat[1:0];
            if (wrMisc) misc_q <= wDat[2:0];
            // Width is double-buffered in 8-bit PWM, loaded at period end; 16-bit PWM compares width_q directly
            if (~running | ~isPwm | periodHit) widthBuf_q <= width_q;
            status_q <= statusNext;
        end
    end

    // Counter, output flip-flop and registered outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_q    <= 8'h00;
            ff_q       <= 1'b0;
            timerOut   <= 1'b0;
            matchPulse <= 1'b0;
            irq        <= 1'b0;
        end else begin
            if (!running) begin
                count_q <= 8'h00;
            end else if (clearCnt) begin
                // A period end clears this unit's byte of the count in timer, divider, 16-bit timer and pulse-gen modes; PWM modes wrap instead
                count_q <= 8'h00;
            end else if (step) begin
                count_q <= count_q + 8'h01;
            end
            if (runStart) begin
                ff_q <= wDat[POS_FF];
            end else if (running & ffSetHit) begin
                ff_q <= ctrl_q.ffCtrl;
            end else if (running & ffToggle) begin
                ff_q <= ~ff_q;
            end
            timerOut   <= pulseMode & ~misc_q[POS_OUTDIS] & ff_q;
            matchPulse <= running & periodHit;
            irq        <= |(status_q & mask_q);
        end
    end
endmodule
`default_nettype wire

// *** verification/upper_timer_chk.sv ***
/*
 Checker for the AXI4-Lite port of the upper timer unit.
 Assumes it is bound to upper_timer and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module upper_timer_chk
    import upper_timer_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_w_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken while answer pending");
    property p_r_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_refuse: assert property (p_r_refuse) else $error("read taken while answer pending");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready)
            || $past(s_axi_wvalid && s_axi_wready);
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("write answer without request");
    property p_r_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_r_cause: assert property (p_r_cause) else $error("read answer without request");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read returns data");
endmodule

bind upper_timer upper_timer_chk chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** verification/test_cascadable_timer_counter_upper_unit.sv ***
/*
 Self-checking bench for the upper timer unit over AXI4-Lite.
 Assumes upper_timer_pkg and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_cascadable_timer_counter_upper_unit;
    import upper_timer_pkg::*;
    logic                sys_clk, nrst, tickEn;
    logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                s_axi_rvalid, s_axi_rready;
    logic [31:0]         s_axi_wdata, s_axi_rdata, rdw;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
    logic                highFreqTick, lowFreqTick, extPin, lowerTick;
    logic                timerOut, matchPulse, irq;
    lower_link_type      lowerLink;
    int                  miscompares, checksDone, seed, gapGot, per, k;
    int                  divs [8] = '{2048, 128, 32, 8, 1, 2, 1, 2};
    logic [7:0]          rstVal [7] = '{RST_CONTROL, RST_PERIOD, RST_WIDTH, {6'h00, RST_IRQ},
                                        {6'h00, RST_IRQ}, 8'h00, {5'h00, RST_MISC}};

    upper_timer dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .highFreqTick(highFreqTick), .lowFreqTick(lowFreqTick),
        .extPin(extPin), .lowerTick(lowerTick), .lowerLink(lowerLink), .timerOut(timerOut),
        .matchPulse(matchPulse), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Every clock source ticks each cycle; the pin rises every second cycle
    always @(posedge sys_clk) begin
        highFreqTick <= tickEn;
        lowFreqTick <= tickEn;
        lowerTick <= tickEn;
        extPin <= ~extPin;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axiWrite(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Cycles between two successive match pulses
    task automatic matchGap(input int lim, output int g);
        int n;
        int first;
        n = 0;
        first = -1;
        g = -1;
        while (n < lim && g < 0) begin
            @(posedge sys_clk);
            n++;
            if (matchPulse === 1'b1) begin
                if (first < 0) first = n;
                else g = n - first;
            end
        end
    endtask

    task automatic printVerdict;
        $display("comparisons %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge sys_clk);
        miscompares++;
        printVerdict();
    end

    initial begin
        seed = 32'h2e2c2331;
        {nrst, tickEn, extPin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        lowerLink = '0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        tickEn <= 1'b1;
        lowerLink.periodLow <= 8'hFF;
        for (k = 0; k < 7; k++) begin
            axiRead(ADDR_W'(k * 4), rdw, rsp);
            check(rdw, {24'h000000, rstVal[k]});
        end
        axiRead(5'h1C, rdw, rsp);
        check({rdw[29:0], rsp}, {30'h0, RESP_SLVERR});
        axiWrite(5'h1C, 8'hFF, rsp);
        check(rsp, RESP_SLVERR);
        axiWrite(OFF_WIDTH, 8'h5A, rsp);
        axiRead(OFF_WIDTH, rdw, rsp);
        check(rdw, 32'h0000005A);
        for (k = 0; k < 8; k++) begin
            per = 2 + ($unsigned($random(seed)) % 4);
            axiWrite(OFF_PERIOD, per[7:0], rsp);
            axiWrite(OFF_CONTROL, {1'b0, k[2:0], 1'b1, 3'h0}, rsp);
            matchGap(3 * per * divs[k] + 40, gapGot);
            check(gapGot, per * divs[k]);
            axiWrite(OFF_CONTROL, {1'b0, k[2:0], 1'b0, 3'h0}, rsp);
        end
        axiWrite(OFF_PERIOD, 8'd200, rsp);
        axiWrite(OFF_MASK, 8'h01, rsp);
        axiWrite(OFF_CONTROL, 8'h68, rsp);
        repeat (250) @(posedge sys_clk);
        axiWrite(OFF_CONTROL, 8'h60, rsp);
        axiRead(OFF_STATUS, rdw, rsp);
        check(rdw[0], 1'b1);
        check(irq, 1'b1);
        axiRead(OFF_COUNT, rdw, rsp);
        check(rdw, 32'h00000000);
        axiWrite(OFF_MASK, 8'h00, rsp);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        axiWrite(OFF_MASK, 8'h01, rsp);
        axiWrite(OFF_STATUS, 8'h01, rsp);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        per = 1 + ($unsigned($random(seed)) % 6);
        axiWrite(OFF_PERIOD, 8'hFF, rsp);
        axiWrite(OFF_CONTROL, 8'h6C, rsp);
        for (k = 0; k < per; k++) begin
            @(posedge sys_clk);
            lowerLink.overflow <= 1'b1;
            @(posedge sys_clk);
            lowerLink.overflow <= 1'b0;
        end
        axiRead(OFF_COUNT, rdw, rsp);
        check(rdw, 32'(per));
        axiWrite(OFF_CONTROL, 8'h64, rsp);
        axiRead(OFF_COUNT, rdw, rsp);
        check(rdw, 32'h00000000);
        axiWrite(OFF_CONTROL, 8'hF9, rsp);
        repeat (3) @(posedge sys_clk);
        check(timerOut, 1'b0);
        axiWrite(OFF_MISC, 8'h00, rsp);
        repeat (3) @(posedge sys_clk);
        check(timerOut, 1'b1);
        axiWrite(OFF_CONTROL, 8'hF1, rsp);
        axiWrite(OFF_CONTROL, 8'h79, rsp);
        repeat (3) @(posedge sys_clk);
        check(timerOut, 1'b0);
        axiWrite(OFF_CONTROL, 8'h71, rsp);
        axiWrite(OFF_CONTROL, 8'hE8, rsp);
        repeat (3) @(posedge sys_clk);
        check(timerOut, 1'b0);
        axiWrite(OFF_CONTROL, 8'hE0, rsp);
        axiWrite(OFF_MISC, 8'h04, rsp);
        axiWrite(OFF_PERIOD, 8'h02, rsp);
        axiWrite(OFF_CONTROL, 8'h68, rsp);
        matchGap(40, gapGot);
        check(gapGot, 32'hFFFFFFFF);
        axiWrite(OFF_CONTROL, 8'h60, rsp);
        axiWrite(OFF_CONTROL, 8'h08, rsp);
        matchGap(80, gapGot);
        check(gapGot, 2 << TAP_FS3);
        printVerdict();
    end
endmodule
`default_nettype wire
